// ==== hw/dphy_tat_pkg.sv ====
// constants, level decoding and register map of the turnaround timeout block
// assumes a 32-bit axi4-lite master; pins may be asynchronous to core_clk and are synchronised in the block
//
// Functional notes
// - the 16-bit turnaround limit is split into a low byte at index 0x10 and a high byte at 0x11, both resetting to 0xFF.
// - the high byte supplies bits 15 to 8 of the limit and is fully readable and writable.
// - a turnaround request reloads the timer to its start state and an acknowledge stops it.
// - if the timer runs out before the acknowledge arrives the turnaround is abandoned.
// - four data lanes are carried and only lane 0 may reverse direction.
// - each lane passes through with its polarity unchanged and no inversion is offered.
// - a low reset pin holds the low-power state and its rising edge resets the digital logic.
// - swing, emphasis and edge-rate fields load from the pins at release and stay writable.

package dphy_tat_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_EDGE_RATE   = 6'h0C;
  localparam logic [5:0] IDX_ANALOG      = 6'h0E;
  localparam logic [5:0] IDX_EQUALISER   = 6'h0F;
  localparam logic [5:0] IDX_LIMIT_LOW   = 6'h10;
  localparam logic [5:0] IDX_LIMIT_HIGH  = 6'h11;
  localparam logic [5:0] IDX_STATUS      = 6'h12;

  localparam logic [7:0] LIMIT_RESET     = 8'hFF;

  // analog register field positions
  localparam int SWING_LSB    = 4;
  localparam int EMPHASIS_LSB = 0;

  // status register bits
  localparam int ST_ACTIVE    = 0;
  localparam int ST_EXPIRED   = 1;
  localparam int ST_LOW_POWER = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int LANES = 4;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } level_e;

  // pin code: bit1 above upper threshold, bit0 above lower threshold
  function automatic level_e decodeLevel(input logic [1:0] code);
    if (code[1])
      return LVL_HIGH;
    else if (code[0])
      return LVL_MID;
    else
      return LVL_LOW;
  endfunction : decodeLevel

endpackage : dphy_tat_pkg

// ==== hw/sync_2ff.sv ====
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level or a clock well below core_clk
`timescale 1ns/1ps

module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule : sync_2ff

// ==== hw/turnaround_timer.sv ====
// down-counting turnaround watchdog driven by low-power clock ticks
// assumes tick, start and ack are one-cycle pulses in the core_clk domain
`timescale 1ns/1ps

module turnaround_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // events
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic             ack,
  input  wire logic [CNT_W-1:0] limit,
  // state
  output logic                  busy,
  output logic                  expired
);

  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_RUN  = 2'b10
  } tstate_e;

  tstate_e          state_reg;
  tstate_e          state_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             expired_next;

  wire countZero = (count_reg == '0);

  always_comb
  begin
    state_next   = state_reg;
    count_next   = count_reg;
    expired_next = 1'b0;
    unique case (state_reg)
      T_IDLE:
      begin
        if (start)
        begin
          count_next = limit;
          state_next = T_RUN;
        end
      end
      T_RUN:
      begin
        if (start)
          count_next = limit;
        else if (ack)
          state_next = T_IDLE;
        else if (tick)
        begin
          if (countZero)
          begin
            expired_next = 1'b1;
            state_next   = T_IDLE;
          end
          else
            count_next = count_reg - 1'b1;
        end
      end
      default:
        state_next = T_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= T_IDLE;
      count_reg <= '0;
      expired   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      expired   <= expired_next;
    end
  end

  assign busy = (state_reg == T_RUN);

endmodule : turnaround_timer

// ==== hw/dphy_turnaround_timeout_reset.sv ====
// digital control of a four-lane retimer: turnaround watchdog, reset release
// and configuration strap capture, with registers over axi4-lite
// assumes all pins are asynchronous to core_clk and the lp clock is far slower
`timescale 1ns/1ps

module dphy_turnaround_timeout_reset
  import dphy_tat_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // reset and configuration pins
  input  wire logic              reset_low_pin,
  input  wire logic [1:0]        swing_select_pin0,
  input  wire logic [1:0]        emphasis_select_pin1,
  input  wire logic [1:0]        equaliser_select_pin,
  input  wire logic [1:0]        edge_rate_pin,
  // lane 0 low-power side
  input  wire logic              lowPowerTxClk,
  input  wire logic              turnaroundReq,
  input  wire logic              turnaroundAck,
  // lane low-power levels
  input  wire logic [LANES-1:0]  laneLevelIn,
  output logic [LANES-1:0]       laneLevelOut,
  output logic [LANES-1:0]       laneReverseEn,
  // status and analog settings
  output logic                   lowPowerMode,
  output logic                   turnaroundActive,
  output logic                   turnaroundAbort,
  output logic [1:0]             swingSel,
  output logic [1:0]             emphasisSel,
  output logic [2*LANES-1:0]     edgeRateSel,
  output logic [1:0]             equaliserSel
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int SYNC_W = 12 + LANES;

  logic [SYNC_W-1:0] pinSync;

  sync_2ff #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .clk     (core_clk),
    .rst     (sys_rst),
    .asyncIn ({reset_low_pin, lowPowerTxClk, turnaroundReq, turnaroundAck,
               swing_select_pin0, emphasis_select_pin1, equaliser_select_pin,
               edge_rate_pin, laneLevelIn}),
    .syncOut (pinSync)
  );

  wire             rstPinS  = pinSync[SYNC_W-1];
  wire             lpClkS   = pinSync[SYNC_W-2];
  wire             reqS     = pinSync[SYNC_W-3];
  wire             ackS     = pinSync[SYNC_W-4];
  wire [1:0]       swingPin = pinSync[LANES+7 -: 2];
  wire [1:0]       empPin   = pinSync[LANES+5 -: 2];
  wire [1:0]       eqPin    = pinSync[LANES+3 -: 2];
  wire [1:0]       edgePin  = pinSync[LANES+1 -: 2];
  wire [LANES-1:0] laneS    = pinSync[LANES-1:0];

  logic rstPinPrev_reg;
  logic lpClkPrev_reg;
  logic reqPrev_reg;
  logic ackPrev_reg;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rstPinPrev_reg <= 1'b0;
      lpClkPrev_reg  <= 1'b0;
      reqPrev_reg    <= 1'b0;
      ackPrev_reg    <= 1'b0;
    end
    else
    begin
      rstPinPrev_reg <= rstPinS;
      lpClkPrev_reg  <= lpClkS;
      reqPrev_reg    <= reqS;
      ackPrev_reg    <= ackS;
    end
  end

  wire releasePulse = rstPinS & ~rstPinPrev_reg;
  wire holdLow      = ~rstPinS;
  wire digRst       = sys_rst | holdLow | releasePulse;
  wire lpTick       = lpClkS & ~lpClkPrev_reg;
  wire reqEdge      = reqS & ~reqPrev_reg;
  wire ackEdge      = ackS & ~ackPrev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // strap decoding, taken only at the release edge

  wire level_e swingLvl = decodeLevel(swingPin);
  wire level_e empLvl   = decodeLevel(empPin);
  wire level_e eqLvl    = decodeLevel(eqPin);
  wire level_e edgeLvl  = decodeLevel(edgePin);

  // swing: middle gives 200 mV; low defers to the emphasis pin
  wire [1:0] swingInit = (swingLvl == LVL_HIGH) ? 2'b10 :
                         (swingLvl == LVL_MID)  ? 2'b01 :
                         (empLvl == LVL_HIGH)   ? 2'b10 : 2'b01;
  wire [1:0] empInit   = (empLvl == LVL_HIGH) ? 2'b10 : 2'b01;
  wire [1:0] edgeInit  = 2'(edgeLvl);
  wire [1:0] eqInit    = 2'(eqLvl);

  //////////////////////////////////////////////////////////////////////////////
  // turnaround watchdog

  logic [7:0] limitLow_reg;
  logic [7:0] limitHigh_reg;
  logic       timerBusy;
  logic       timerExpired;

  wire [15:0] limitValue = {limitHigh_reg, limitLow_reg};

  turnaround_timer #(
    .CNT_W (16)
  ) u_timer (
    .clk     (core_clk),
    .rst     (digRst),
    .tick    (lpTick),
    .start   (reqEdge),
    .ack     (ackEdge),
    .limit   (limitValue),
    .busy    (timerBusy),
    .expired (timerExpired)
  );

  // only lane 0 turns round; others stay forward
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      turnaroundActive <= 1'b0;
      turnaroundAbort  <= 1'b0;
      laneReverseEn    <= '0;
      laneLevelOut     <= '0;
      lowPowerMode     <= 1'b1;
    end
    else
    begin
      turnaroundActive <= timerBusy;
      turnaroundAbort  <= timerExpired;
      laneReverseEn    <= {{(LANES-1){1'b0}}, timerBusy};
      laneLevelOut     <= laneS;
      lowPowerMode     <= holdLow;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  logic [5:0]  wrIdx_reg;
  logic        awHave_reg;
  logic [7:0]  wByte_reg;
  logic        wLane0_reg;
  logic        wHave_reg;
  logic        expiredSticky_reg;

  wire awTake  = awvalid & awready;
  wire wTake   = wvalid & wready;
  wire doWrite = awHave_reg & wHave_reg & ~bvalid;
  wire wrEn    = doWrite & wLane0_reg;

  wire wrMapped = (wrIdx_reg == IDX_EDGE_RATE) | (wrIdx_reg == IDX_ANALOG) |
                  (wrIdx_reg == IDX_EQUALISER) | (wrIdx_reg == IDX_LIMIT_LOW) |
                  (wrIdx_reg == IDX_LIMIT_HIGH) | (wrIdx_reg == IDX_STATUS);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      awready    <= 1'b0;
      wready     <= 1'b0;
      awHave_reg <= 1'b0;
      wHave_reg  <= 1'b0;
      wrIdx_reg  <= '0;
      wByte_reg  <= '0;
      wLane0_reg <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end
    else
    begin
      awready <= ~awHave_reg & ~awTake & ~doWrite;
      wready  <= ~wHave_reg & ~wTake & ~doWrite;
      if (awTake)
      begin
        awHave_reg <= 1'b1;
        wrIdx_reg  <= awaddr[7:2];
      end
      if (wTake)
      begin
        wHave_reg  <= 1'b1;
        wByte_reg  <= wdata[7:0];
        wLane0_reg <= wstrb[0];
      end
      if (doWrite)
      begin
        awHave_reg <= 1'b0;
        wHave_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid & bready)
        bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; release edge reloads the limits like a full reset and the analog fields from the straps

  wire wrLimLo = wrEn & (wrIdx_reg == IDX_LIMIT_LOW);
  wire wrLimHi = wrEn & (wrIdx_reg == IDX_LIMIT_HIGH);
  wire wrAna   = wrEn & (wrIdx_reg == IDX_ANALOG);
  wire wrEdge  = wrEn & (wrIdx_reg == IDX_EDGE_RATE);
  wire wrEq    = wrEn & (wrIdx_reg == IDX_EQUALISER);
  wire wrStat  = wrEn & (wrIdx_reg == IDX_STATUS);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst | releasePulse)
    begin
      limitLow_reg  <= LIMIT_RESET;
      limitHigh_reg <= LIMIT_RESET;
    end
    else
    begin
      if (wrLimLo)
        limitLow_reg <= wByte_reg;
      if (wrLimHi)
        limitHigh_reg <= wByte_reg;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      swingSel     <= '0;
      emphasisSel  <= '0;
      edgeRateSel  <= '0;
      equaliserSel <= '0;
    end
    else if (releasePulse)
    begin
      swingSel     <= swingInit;
      emphasisSel  <= empInit;
      edgeRateSel  <= {LANES{edgeInit}};
      equaliserSel <= eqInit;
    end
    else
    begin
      if (wrAna)
      begin
        swingSel    <= wByte_reg[SWING_LSB +: 2];
        emphasisSel <= wByte_reg[EMPHASIS_LSB +: 2];
      end
      if (wrEdge)
        edgeRateSel <= wByte_reg;
      if (wrEq)
        equaliserSel <= wByte_reg[1:0];
    end
  end

  // expiry flag: a new expiry beats a same-cycle clear
  always_ff @(posedge core_clk)
  begin
    if (sys_rst | releasePulse)
      expiredSticky_reg <= 1'b0;
    else if (timerExpired)
      expiredSticky_reg <= 1'b1;
    else if (wrStat & wByte_reg[ST_EXPIRED])
      expiredSticky_reg <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  wire [5:0] rdIdx = araddr[7:2];

  wire [7:0] statusByte = {5'h00, lowPowerMode, expiredSticky_reg, turnaroundActive};

  wire [7:0] rdByte =
      (rdIdx == IDX_EDGE_RATE)  ? edgeRateSel :
      (rdIdx == IDX_ANALOG)     ? {2'b00, swingSel, 2'b00, emphasisSel} :
      (rdIdx == IDX_EQUALISER)  ? {6'h00, equaliserSel} :
      (rdIdx == IDX_LIMIT_LOW)  ? limitLow_reg :
      (rdIdx == IDX_LIMIT_HIGH) ? limitHigh_reg :
      (rdIdx == IDX_STATUS)     ? statusByte : 8'h00;

  wire rdMapped = (rdIdx == IDX_EDGE_RATE) | (rdIdx == IDX_ANALOG) |
                  (rdIdx == IDX_EQUALISER) | (rdIdx == IDX_LIMIT_LOW) |
                  (rdIdx == IDX_LIMIT_HIGH) | (rdIdx == IDX_STATUS);

  wire arTake = arvalid & arready;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      if (arTake)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h00_0000, rdByte};
        rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid & rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
      else if (~rvalid)
        arready <= 1'b1;
    end
  end

endmodule : dphy_turnaround_timeout_reset

// ==== bench/tat_far_side.sv ====
// far-side model: lane 0 partner driving the low-power clock, request and acknowledge
// assumes the bench calls run() and reads lpEdges; clock stands still between turnarounds
`timescale 1ns/1ps

module tat_far_side (
  // lane 0 low-power side
  output logic lpClk,
  output logic req,
  output logic ack
);
  int lpEdges;

  initial
  begin
    lpClk = 1'b0;
    req = 1'b0;
    ack = 1'b0;
    lpEdges = 0;
  end

  ////////////////////////////////////////
  // request held for the whole window; odd offset keeps it off core_clk edges
  task automatic run(input int edges, input bit answer);
    lpEdges = 0;
    req = 1'b1;
    #103;
    repeat (edges)
    begin
      lpClk = 1'b1;
      lpEdges++;
      #80;
      lpClk = 1'b0;
      #80;
    end
    ack = answer;
    #200;
    req = 1'b0;
    ack = 1'b0;
    #200;
  endtask : run
endmodule : tat_far_side

// ==== bench/dphy_turnaround_timeout_reset_checker.sv ====
// port-level properties of the turnaround timeout block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps

module dphy_turnaround_timeout_reset_checker
  import dphy_tat_pkg::*;
(
  // clock and reset
  input wire logic             core_clk,
  input wire logic             sys_rst,
  // bus answers
  input wire logic             bvalid,
  input wire logic             bready,
  input wire logic [1:0]       bresp,
  input wire logic             rvalid,
  input wire logic             rready,
  input wire logic [31:0]      rdata,
  // pins and status
  input wire logic             reset_low_pin,
  input wire logic             turnaroundReq,
  input wire logic             turnaroundAck,
  input wire logic [LANES-1:0] laneLevelIn,
  input wire logic [LANES-1:0] laneLevelOut,
  input wire logic [LANES-1:0] laneReverseEn,
  input wire logic             lowPowerMode,
  input wire logic             turnaroundActive,
  input wire logic             turnaroundAbort
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // lane pipe needs three edges to fill after reset
  logic [2:0] upCnt_reg;
  always_ff @(posedge core_clk)
    if (sys_rst)
      upCnt_reg <= 3'h0;
    else if (upCnt_reg != 3'h7)
      upCnt_reg <= upCnt_reg + 3'h1;

  ////////////////////////////////////////
  a_lane_passthru: assert property (upCnt_reg == 3'h7 && !lowPowerMode
    |-> laneLevelOut == $past(laneLevelIn, 3)) else $error("lane level not passed through");
  a_reverse_lane0: assert property (laneReverseEn == {3'h0, turnaroundActive})
    else $error("reverse enable outside lane 0");
  a_req_starts: assert property ($rose(turnaroundReq) && !lowPowerMode
    |-> ##[3:6] turnaroundActive) else $error("request did not start timer");
  a_ack_stops: assert property ($rose(turnaroundAck) && turnaroundActive
    |-> ##[3:6] !turnaroundActive) else $error("acknowledge did not stop timer");
  a_abort_pulse: assert property (turnaroundAbort |-> !turnaroundActive
    && $past(turnaroundActive) ##1 !turnaroundAbort) else $error("abort pulse malformed");
  a_lowpower_hold: assert property ((!reset_low_pin)[*4] |-> lowPowerMode)
    else $error("low-power state not entered");
  a_lowpower_idle: assert property (lowPowerMode && $past(lowPowerMode)
    |-> !turnaroundActive) else $error("timer running in low-power state");
  a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
endmodule : dphy_turnaround_timeout_reset_checker

// ==== bench/dphy_turnaround_timeout_reset_tb.sv ====
// testbench: bus, turnaround, lane and reset scenarios of the turnaround block
// assumes the far-side model and the checker are compiled before it
`timescale 1ns/1ps

module dphy_turnaround_timeout_reset_tb;
  import dphy_tat_pkg::*;

  logic        core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, reset_low_pin, abortSeen, activeSeen;
  logic        lowPowerTxClk, turnaroundReq, turnaroundAck;
  logic        lowPowerMode, turnaroundActive, turnaroundAbort;
  logic [7:0]  awaddr, araddr, edgeRateSel;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, swingSel, emphasisSel, equaliserSel;
  logic [1:0]  swing_select_pin0, emphasis_select_pin1, equaliser_select_pin, edge_rate_pin;
  logic [3:0]  laneLevelIn, laneLevelOut, laneReverseEn;
  int          errTotal, totalChecks, cycles, abortEdges;
  logic [15:0] lims [3] = '{16'h0001, 16'h0002, 16'h0100};

  dphy_turnaround_timeout_reset dut (.core_clk, .sys_rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .reset_low_pin, .swing_select_pin0,
    .emphasis_select_pin1, .equaliser_select_pin, .edge_rate_pin, .lowPowerTxClk,
    .turnaroundReq, .turnaroundAck, .laneLevelIn, .laneLevelOut, .laneReverseEn,
    .lowPowerMode, .turnaroundActive, .turnaroundAbort, .swingSel, .emphasisSel,
    .edgeRateSel, .equaliserSel);

  tat_far_side far (.lpClk(lowPowerTxClk), .req(turnaroundReq), .ack(turnaroundAck));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // run ceiling well above the ~35k cycles the scenarios need
  always @(posedge core_clk)
  begin
    cycles++;
    if (turnaroundAbort === 1'b1 && abortSeen !== 1'b1)
    begin
      abortSeen <= 1'b1;
      abortEdges <= far.lpEdges;
    end
    if (turnaroundActive === 1'b1)
      activeSeen <= 1'b1;
    if (cycles == 50000)
    begin
      errTotal++;
      results();
    end
  end

  ////////////////////////////////////////
  task automatic results();
    if (errTotal == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      errTotal++;
    end
  endtask : chk

  // response ready raised only after valid, so the slave must hold its answer
  task automatic axWrite(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge core_clk);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : axWrite

  task automatic axRead(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(posedge core_clk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge core_clk);
    while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge core_clk);
    rready <= 1'b0;
    chk("rdata", {24'h00_0000, ed}, rdata);
    chk("rresp", er, rresp);
  endtask : axRead

  ////////////////////////////////////////
  task automatic t_registers();
    axRead(8'h40, 8'hFF, RESP_OKAY);
    axRead(8'h44, 8'hFF, RESP_OKAY);
    axRead(8'h38, 8'h11, RESP_OKAY);
    axRead(8'h30, 8'hAA, RESP_OKAY);
    axRead(8'h3C, 8'h00, RESP_OKAY);
    chk("edgeRateSel", 8'hAA, edgeRateSel);
    chk("swingSel", 2'h1, swingSel);
    axWrite(8'h44, 8'hA5, RESP_OKAY);
    axRead(8'h44, 8'hA5, RESP_OKAY);
    axWrite(8'h38, 8'h21, RESP_OKAY);
    chk("swingSel", 2'h2, swingSel);
    axWrite(8'hFC, 8'h5A, RESP_SLVERR);
    axRead(8'hFC, 8'h00, RESP_SLVERR);
  endtask : t_registers

  task automatic t_expire(input logic [15:0] lim);
    axWrite(8'h40, lim[7:0], RESP_OKAY);
    axWrite(8'h44, lim[15:8], RESP_OKAY);
    abortSeen <= 1'b0;
    far.run(int'(lim) + 3, 1'b0);
    @(posedge core_clk);
    chk("abortSeen", 1'b1, abortSeen);
    chk("abortEdges", lim + 1, abortEdges);
    chk("turnaroundActive", 1'b0, turnaroundActive);
    // sticky expiry bit, then write-one-clear
    axRead(8'h48, 8'h02, RESP_OKAY);
    axWrite(8'h48, 8'h02, RESP_OKAY);
    axRead(8'h48, 8'h00, RESP_OKAY);
  endtask : t_expire

  task automatic t_ack();
    axWrite(8'h40, 8'h05, RESP_OKAY);
    axWrite(8'h44, 8'h00, RESP_OKAY);
    {abortSeen, activeSeen} <= 2'h0;
    // five edges run the count to zero; a sixth would expire
    far.run(5, 1'b1);
    chk("turnaroundActive", 1'b0, turnaroundActive);
    far.run(4, 1'b0);
    @(posedge core_clk);
    chk("activeSeen", 1'b1, activeSeen);
    chk("abortSeen", 1'b0, abortSeen);
  endtask : t_ack

  task automatic t_lanes();
    for (int i = 0; i < 5; i++)
    begin
      laneLevelIn <= (i == 4) ? 4'hA : 4'(1 << i);
      repeat (5) @(posedge core_clk);
      chk("laneLevelOut", (i == 4) ? 4'hA : 4'(1 << i), laneLevelOut);
    end
  endtask : t_lanes

  task automatic t_lowpower();
    // straps stay put 250 us past the first release
    while (cycles < 35010) @(posedge core_clk);
    reset_low_pin <= 1'b0;
    edge_rate_pin <= 2'h0;
    repeat (10) @(posedge core_clk);
    chk("lowPowerMode", 1'b1, lowPowerMode);
    activeSeen <= 1'b0;
    far.run(2, 1'b0);
    @(posedge core_clk);
    chk("activeSeen", 1'b0, activeSeen);
    reset_low_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("lowPowerMode", 1'b0, lowPowerMode);
    chk("edgeRateSel", 8'h00, edgeRateSel);
    axRead(8'h40, 8'hFF, RESP_OKAY);
  endtask : t_lowpower

  initial
  begin
    {sys_rst, reset_low_pin, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wdata, laneLevelIn} = 52'h0_0000_0000_0000;
    {errTotal, totalChecks, cycles} = '0;
    {abortSeen, activeSeen, abortEdges} <= '0;
    swing_select_pin0 = 2'h1;
    emphasis_select_pin1 = 2'h1;
    equaliser_select_pin = 2'h0;
    edge_rate_pin = 2'h2;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (10000) @(posedge core_clk);
    chk("lowPowerMode", 1'b1, lowPowerMode);
    reset_low_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_registers();
    foreach (lims[k])
      t_expire(lims[k]);
    t_ack();
    t_lanes();
    t_lowpower();
    results();
  end
endmodule : dphy_turnaround_timeout_reset_tb

bind dphy_turnaround_timeout_reset dphy_turnaround_timeout_reset_checker chk_u (.core_clk,
  .sys_rst, .bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .reset_low_pin,
  .turnaroundReq, .turnaroundAck, .laneLevelIn, .laneLevelOut, .laneReverseEn,
  .lowPowerMode, .turnaroundActive, .turnaroundAbort);
